// ==== logic/autoneg_cfg.svh ====
// offsets, field positions, reset values and timing for the autoneg bank
`ifndef AUTONEG_CFG_SVH
`define AUTONEG_CFG_SVH

`define REG_ID_HIGH 5'h02
`define REG_ID_LOW 5'h03
`define REG_ADVERT 5'h04
`define REG_PARTNER 5'h05
`define REG_EXPAND 5'h06
`define REG_NP_TX 5'h07
`define REG_NP_RX 5'h08

`define ADV_WMASK 16'hBFFF
`define ADV_SEL_RST 5'h01
`define NP_WMASK 16'hB7FF
`define NP_RST 16'h2001
`define NP_TOGGLE_BIT 11
`define EXP_PDF_BIT 4
`define EXP_LOCNP_BIT 2
`define EXP_PAGE_BIT 1

`define OP_READ 2'b10
`define OP_WRITE 2'b01
`define PRE_LEN 6'h20

`define CLK_PERIOD_PS 5000
`define SW_RST_TIME_NS 4000
`define SW_RST_CYC \
  ((`SW_RST_TIME_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

`endif

// ==== logic/autoneg_pkg.sv ====
// types shared by the autoneg register bank
package autoneg_pkg;
  typedef enum logic [2:0] {
    ST_PRE = 3'b000,
    ST_HDR = 3'b001,
    ST_TA = 3'b010,
    ST_RD = 3'b011,
    ST_WR = 3'b100
  } mgmt_state_t;
endpackage

// ==== logic/pin_sync.sv ====
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1
) (
  input wire logic ref_clk,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_r;

  // no reset: straps must reach the defaults while the bank is held in reset
  // meta_r feeds only the second stage
  always_ff @(posedge ref_clk) begin
    meta_r <= async_in;
    sync_out <= meta_r;
  end
endmodule // pin_sync

// ==== logic/autoneg_ident_register_bank.sv ====
// autoneg and identification registers behind the serial management port
`timescale 1ns/1ps
`include "autoneg_cfg.svh"
module autoneg_ident_register_bank import autoneg_pkg::*; #(
  parameter logic [4:0] PHY_ADDR = 5'h00,
  // identity values below are arbitrary
  parameter logic [15:0] ORG_ID_HI = 16'h1C3B,
  parameter logic [5:0] ORG_ID_LO = 6'h2A,
  parameter logic [5:0] MODEL_ID = 6'h15,
  parameter logic [3:0] REVISION = 4'h3
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic mgmt_clk_pin,
  input wire logic mgmt_data_i,
  output logic mgmt_data_o,
  output logic mgmt_data_oe,
  input wire logic [5:0] config_strap_default,
  input wire logic soft_rst_req,
  input wire logic link_partner_base_valid,
  input wire logic [15:0] link_partner_base_page,
  input wire logic link_partner_np_valid,
  input wire logic [15:0] link_partner_next_page,
  input wire logic par_det_fault,
  input wire logic page_rx_live,
  input wire logic link_partner_np_able,
  input wire logic link_partner_an_able,
  input wire logic link_codeword_sent,
  input wire logic link_codeword_toggle,
  output logic [15:0] advert_word,
  output logic [15:0] np_tx_word,
  output logic mgmt_busy
);
  logic mdc_s;
  logic mdio_s;
  logic [5:0] strap_s;
  logic mdc_q_r;
  logic mdc_rise;
  mgmt_state_t state_r;
  logic [5:0] pre_cnt_r;
  logic [4:0] bit_cnt_r;
  logic [11:0] hdr_r;
  logic [12:0] hdr_full;
  logic hdr_ok;
  logic hdr_rd_hit;
  logic hdr_wr_hit;
  logic is_rd_r;
  logic [4:0] addr_r;
  logic [15:0] rd_shift_r;
  logic [15:0] wr_shift_r;
  logic wr_en;
  logic [15:0] wr_data;
  logic [15:0] rd_word;
  logic [15:0] adv_dflt;
  logic [15:0] partner_base_r;
  logic [15:0] partner_np_r;
  logic pdf_r;
  logic page_lat_r;
  logic [9:0] busy_cnt_r;
  logic def_load;
  logic exp_read;

  pin_sync #(
    .W(8)
  ) u_sync (
    .ref_clk(ref_clk),
    .async_in({mgmt_clk_pin, mgmt_data_i, config_strap_default}),
    .sync_out({mdc_s, mdio_s, strap_s})
  );

  // defaults are forced while reset or the soft reset window lasts
  assign def_load = srst | soft_rst_req | mgmt_busy;
  // pin clock idles low, so mdc_q_r resets low and no false edge follows
  assign mdc_rise = mdc_s & ~mdc_q_r;
  assign hdr_full = {hdr_r, mdio_s};
  assign hdr_ok = hdr_full[12] && (hdr_full[9:5] == PHY_ADDR);
  assign hdr_rd_hit = mdc_rise && (state_r == ST_HDR) &&
    (bit_cnt_r == 5'd12) && hdr_ok && (hdr_full[11:10] == `OP_READ);
  assign hdr_wr_hit = mdc_rise && (state_r == ST_HDR) &&
    (bit_cnt_r == 5'd12) && hdr_ok && (hdr_full[11:10] == `OP_WRITE);
  assign exp_read = hdr_rd_hit && (hdr_full[4:0] == `REG_EXPAND);
  assign wr_en = mdc_rise && (state_r == ST_WR) && (bit_cnt_r == 5'd15);
  assign wr_data = {wr_shift_r[14:0], mdio_s};
  assign adv_dflt = {4'h0, strap_s[5:4], 1'b0, strap_s[3:0], `ADV_SEL_RST};

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      mdc_q_r <= 1'b0;
    end else begin
      mdc_q_r <= mdc_s;
    end
  end

  // soft reset window; accesses inside it are ignored
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      mgmt_busy <= 1'b0;
      busy_cnt_r <= '0;
    end else if (soft_rst_req) begin
      mgmt_busy <= 1'b1;
      busy_cnt_r <= '0;
    end else if (mgmt_busy) begin
      if (busy_cnt_r == 10'(`SW_RST_CYC - 1)) begin
        mgmt_busy <= 1'b0;
      end
      busy_cnt_r <= busy_cnt_r + 10'd1;
    end
  end

  // frame engine, stepped on each rising edge of the management clock
  always_ff @(posedge ref_clk) begin
    if (def_load) begin
      state_r <= ST_PRE;
      pre_cnt_r <= '0;
      bit_cnt_r <= '0;
      hdr_r <= '0;
      is_rd_r <= 1'b0;
      addr_r <= '0;
      wr_shift_r <= '0;
      mgmt_data_o <= 1'b0;
      mgmt_data_oe <= 1'b0;
    end else if (mdc_rise) begin
      case (state_r)
        ST_PRE: begin
          if (mdio_s) begin
            if (pre_cnt_r != `PRE_LEN) begin
              pre_cnt_r <= pre_cnt_r + 6'd1;
            end
          end else begin
            if (pre_cnt_r == `PRE_LEN) begin
              state_r <= ST_HDR;
              bit_cnt_r <= '0;
            end
            pre_cnt_r <= '0;
          end
        end
        ST_HDR: begin
          hdr_r <= hdr_full[11:0];
          bit_cnt_r <= bit_cnt_r + 5'd1;
          if (bit_cnt_r == 5'd12) begin
            bit_cnt_r <= '0;
            addr_r <= hdr_full[4:0];
            is_rd_r <= hdr_rd_hit;
            // frames for another port or with a bad opcode are dropped
            state_r <= (hdr_rd_hit || hdr_wr_hit) ? ST_TA : ST_PRE;
          end
        end
        ST_TA: begin
          // reads take the line from the first turnaround bit
          if (is_rd_r) begin
            mgmt_data_oe <= 1'b1;
            mgmt_data_o <= 1'b0;
            state_r <= ST_RD;
            bit_cnt_r <= '0;
          end else if (bit_cnt_r == 5'd1) begin
            state_r <= ST_WR;
            bit_cnt_r <= '0;
          end else begin
            bit_cnt_r <= bit_cnt_r + 5'd1;
          end
        end
        ST_RD: begin
          if (bit_cnt_r == 5'd16) begin
            mgmt_data_oe <= 1'b0;
            mgmt_data_o <= 1'b0;
            state_r <= ST_PRE;
          end else begin
            mgmt_data_o <= rd_shift_r[15 - bit_cnt_r[3:0]];
            bit_cnt_r <= bit_cnt_r + 5'd1;
          end
        end
        ST_WR: begin
          wr_shift_r <= wr_data;
          bit_cnt_r <= bit_cnt_r + 5'd1;
          if (bit_cnt_r == 5'd15) begin
            state_r <= ST_PRE;
          end
        end
        default: begin
          state_r <= ST_PRE;
        end
      endcase
    end
  end

  always_comb begin
    case (hdr_full[4:0])
      `REG_ID_HIGH: rd_word = ORG_ID_HI;
      `REG_ID_LOW: rd_word = {ORG_ID_LO, MODEL_ID, REVISION};
      `REG_ADVERT: rd_word = advert_word;
      `REG_PARTNER: rd_word = partner_base_r;
      `REG_EXPAND: rd_word = {11'h000, pdf_r, link_partner_np_able,
        1'b1, page_lat_r, link_partner_an_able};
      `REG_NP_TX: rd_word = np_tx_word;
      `REG_NP_RX: rd_word = partner_np_r;
      default: rd_word = 16'h0000;
    endcase
  end

  // read data frozen at the end of the header
  always_ff @(posedge ref_clk) begin
    if (def_load) begin
      rd_shift_r <= '0;
    end else if (hdr_rd_hit) begin
      rd_shift_r <= rd_word;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (def_load) begin
      advert_word <= adv_dflt;
    end else if (wr_en && addr_r == `REG_ADVERT) begin
      advert_word <= wr_data & `ADV_WMASK;
    end
  end

  // bit 11 follows sent codewords only; a port write leaves it alone
  always_ff @(posedge ref_clk) begin
    if (def_load) begin
      np_tx_word <= `NP_RST;
    end else begin
      if (wr_en && addr_r == `REG_NP_TX) begin
        np_tx_word <= (wr_data & `NP_WMASK) |
          (np_tx_word & ~`NP_WMASK);
      end
      if (link_codeword_sent) begin
        np_tx_word[`NP_TOGGLE_BIT] <= ~link_codeword_toggle;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (def_load) begin
      partner_base_r <= '0;
    end else if (link_partner_base_valid) begin
      partner_base_r <= link_partner_base_page;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (def_load) begin
      partner_np_r <= '0;
    end else if (link_partner_np_valid) begin
      partner_np_r <= link_partner_next_page;
    end
  end

  // a fault in the read cycle wins over the read's clear
  always_ff @(posedge ref_clk) begin
    if (def_load) begin
      pdf_r <= 1'b0;
    end else if (par_det_fault) begin
      pdf_r <= 1'b1;
    end else if (exp_read) begin
      pdf_r <= 1'b0;
    end
  end

  // a drop of the live level wins over the read's restore
  always_ff @(posedge ref_clk) begin
    if (def_load) begin
      page_lat_r <= 1'b0;
    end else if (!page_rx_live) begin
      page_lat_r <= 1'b0;
    end else if (exp_read) begin
      page_lat_r <= 1'b1;
    end
  end

  // checks below are off while srst is high
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  id_high_read_a: assert property (hdr_rd_hit &&
    hdr_full[4:0] == `REG_ID_HIGH |=> rd_shift_r == ORG_ID_HI)
    else $error("id high read wrong");
  id_low_read_a: assert property (hdr_rd_hit &&
    hdr_full[4:0] == `REG_ID_LOW |=>
    rd_shift_r == {ORG_ID_LO, MODEL_ID, REVISION})
    else $error("id low read wrong");
  advert_rsvd_a: assert property (advert_word[14] == 1'b0)
    else $error("advert bit 14 set");
  advert_dflt_a: assert property ($past(soft_rst_req) |->
    advert_word[11:10] == $past(strap_s[5:4]) &&
    advert_word[9] == 1'b0 && advert_word[4:0] == `ADV_SEL_RST)
    else $error("advert default wrong");
  np_dflt_a: assert property ($past(soft_rst_req) |->
    np_tx_word == `NP_RST)
    else $error("next page default wrong");
  partner_clear_a: assert property ($past(soft_rst_req) |->
    partner_base_r == 16'h0000 && partner_np_r == 16'h0000)
    else $error("partner words not cleared");
  fault_latch_a: assert property (par_det_fault && !def_load |=>
    pdf_r)
    else $error("fault not latched");
  fault_hold_a: assert property (pdf_r && !exp_read && !def_load |=>
    pdf_r)
    else $error("fault dropped before read");
  page_low_a: assert property (!page_rx_live && !def_load |=>
    !page_lat_r)
    else $error("page latch not low");
  read_restore_a: assert property (exp_read && !par_det_fault &&
    !def_load |=> !pdf_r)
    else $error("fault not restored on read");
  page_restore_a: assert property (exp_read && page_rx_live &&
    !def_load |=> page_lat_r)
    else $error("page latch not restored on read");
  toggle_inv_a: assert property (link_codeword_sent && !def_load |=>
    np_tx_word[`NP_TOGGLE_BIT] == !$past(link_codeword_toggle))
    else $error("toggle not inverted");
  busy_hold_a: assert property (soft_rst_req |=> mgmt_busy [*8])
    else $error("soft reset window short");
  busy_len_a: assert property ($fell(mgmt_busy) |->
    $past(busy_cnt_r) == 10'(`SW_RST_CYC - 1))
    else $error("soft reset window length wrong");
  busy_idle_a: assert property (mgmt_busy |->
    state_r == ST_PRE && !mgmt_data_oe)
    else $error("frame taken during soft reset");
  exp_fixed_a: assert property (hdr_rd_hit &&
    hdr_full[4:0] == `REG_EXPAND |=>
    rd_shift_r[15:5] == 11'h000 && rd_shift_r[`EXP_LOCNP_BIT])
    else $error("expansion fixed bits wrong");
  advert_write_a: assert property (wr_en && !def_load &&
    addr_r == `REG_ADVERT |=>
    advert_word == ($past(wr_data) & `ADV_WMASK))
    else $error("advert write not applied");
  np_write_a: assert property (wr_en && !def_load &&
    addr_r == `REG_NP_TX && !link_codeword_sent |=>
    np_tx_word == (($past(wr_data) & `NP_WMASK) |
    ($past(np_tx_word) & ~`NP_WMASK)))
    else $error("next page write not applied");
  partner_take_a: assert property (link_partner_base_valid &&
    !def_load |=> partner_base_r == $past(link_partner_base_page))
    else $error("partner base page not taken");
  partner_np_take_a: assert property (link_partner_np_valid &&
    !def_load |=> partner_np_r == $past(link_partner_next_page))
    else $error("partner next page not taken");

  read_frame_c: cover property (hdr_rd_hit);
  write_advert_c: cover property (wr_en && addr_r == `REG_ADVERT);
  soft_reset_c: cover property ($fell(mgmt_busy));
  fault_read_c: cover property (pdf_r && exp_read);
  page_drop_c: cover property (!page_rx_live && page_lat_r);
endmodule // autoneg_ident_register_bank

// ==== verif/mgmt_ctrl_model.sv ====
// station management controller model for the serial mgmt pins
`timescale 1ns/1ps
`include "autoneg_cfg.svh"
module mgmt_ctrl_model (
  input wire logic ref_clk,
  input wire logic mgmt_data_o,
  input wire logic mgmt_data_oe,
  output logic mgmt_clk_pin,
  output logic mgmt_data_i
);
  logic drv;
  // pull-up keeps the data line high whenever nobody drives it
  assign mgmt_data_i = mgmt_data_oe ? mgmt_data_o : drv;
  initial begin
    mgmt_clk_pin = 1'b0;
    drv = 1'b1;
  end
  // ten ref_clk per half keeps the device's synchroniser well inside
  task automatic half();
    repeat (10) @(posedge ref_clk);
    #1;
  endtask
  task automatic bit_t(input logic b, output logic s);
    mgmt_clk_pin = 1'b0;
    drv = b;
    half();
    mgmt_clk_pin = 1'b1;
    half();
    s = mgmt_data_i;
  endtask
  task automatic frame(input logic [1:0] op, input logic [4:0] ra,
    input logic [15:0] wd, output logic [15:0] rd);
    logic [45:0] hdr;
    logic s;
    hdr = {32'hFFFFFFFF, 2'b01, op, 5'h00, ra};
    rd = 16'h0000;
    for (int i = 45; i >= 0; i--) bit_t(hdr[i], s);
    // released during turnaround so the device can take the line
    bit_t(1'b1, s);
    if (op != `OP_READ) bit_t(1'b0, s);
    for (int i = 15; i >= 0; i--) begin
      bit_t(op == `OP_READ ? 1'b1 : wd[i], s);
      rd[i] = s;
    end
    bit_t(1'b1, s);
    mgmt_clk_pin = 1'b0;
    drv = 1'b1;
    half();
  endtask
endmodule // mgmt_ctrl_model

// ==== verif/testbench.sv ====
// self-checking bench for the autoneg register bank
`timescale 1ns/1ps
`include "autoneg_cfg.svh"
`define CHK(n, e, s) chk(n, e, s)
module testbench;
  // identity values are arbitrary
  localparam logic [15:0] IDH = 16'h4D21;
  localparam logic [15:0] IDL = {6'h19, 6'h0B, 4'h6};
  localparam logic [15:0] ADV = 16'h09A1;
  logic ref_clk, srst, mclk, mdi, mdo, mdoe, soft_rst_req, busy;
  logic pb_v, pn_v, pdf, page_live, nxt_able, an_able, cw_sent, cw_tog;
  logic [5:0] strap;
  logic [15:0] pb, pn, advert_word, np_tx_word, rd;
  int mismatches, total_checks, n;
  autoneg_ident_register_bank #(.ORG_ID_HI(IDH), .ORG_ID_LO(IDL[15:10]),
    .MODEL_ID(IDL[9:4]), .REVISION(IDL[3:0])) dut_u (
    .ref_clk(ref_clk), .srst(srst), .mgmt_clk_pin(mclk),
    .mgmt_data_i(mdi), .mgmt_data_o(mdo), .mgmt_data_oe(mdoe),
    .config_strap_default(strap), .soft_rst_req(soft_rst_req),
    .link_partner_base_valid(pb_v), .link_partner_base_page(pb),
    .link_partner_np_valid(pn_v), .link_partner_next_page(pn),
    .par_det_fault(pdf), .page_rx_live(page_live),
    .link_partner_np_able(nxt_able), .link_partner_an_able(an_able),
    .link_codeword_sent(cw_sent), .link_codeword_toggle(cw_tog),
    .advert_word(advert_word), .np_tx_word(np_tx_word), .mgmt_busy(busy));
  mgmt_ctrl_model mm_u (.ref_clk(ref_clk), .mgmt_data_o(mdo),
    .mgmt_data_oe(mdoe), .mgmt_clk_pin(mclk), .mgmt_data_i(mdi));
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  task automatic chk(string nm, logic [15:0] e, logic [15:0] s);
    total_checks++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic cyc(int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(logic [4:0] a, logic [15:0] d);
    mm_u.frame(`OP_WRITE, a, d, rd);
  endtask
  task automatic rc(string nm, logic [4:0] a, logic [15:0] e);
    mm_u.frame(`OP_READ, a, 16'h0000, rd);
    `CHK(nm, e, rd);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    cyc(80000);
    mismatches++;
    test_done();
  end
  initial begin
    srst = 1'b1;
    {soft_rst_req, pb_v, pn_v, pdf, cw_sent, cw_tog} = '0;
    {page_live, nxt_able, an_able} = 3'b111;
    strap = 6'h2D;
    pb = 16'h0000;
    pn = 16'h0000;
    cyc(5);
    srst = 1'b0;
    `CHK("advert_port", ADV, advert_word);
    `CHK("np_tx_port", 16'h2001, np_tx_word);
    rc("id_high", `REG_ID_HIGH, IDH);
    rc("id_low", `REG_ID_LOW, IDL);
    wr(`REG_ID_HIGH, 16'h0000);
    rc("id_high_ro", `REG_ID_HIGH, IDH);
    wr(`REG_ID_LOW, 16'h0000);
    rc("id_low_ro", `REG_ID_LOW, IDL);
    rc("advert_rst", `REG_ADVERT, ADV);
    wr(`REG_ADVERT, 16'hFFFF);
    rc("advert_ones", `REG_ADVERT, 16'hBFFF);
    wr(`REG_ADVERT, 16'h5000);
    rc("advert_res", `REG_ADVERT, 16'h1000);
    rc("np_tx_rst", `REG_NP_TX, 16'h2001);
    wr(`REG_NP_TX, 16'hFFFF);
    rc("np_tx_ones", `REG_NP_TX, 16'hB7FF);
    for (int t = 0; t < 2; t++) begin
      cw_tog = t[0];
      cw_sent = 1'b1;
      cyc(1);
      cw_sent = 1'b0;
      cyc(1);
      `CHK("toggle", {4'h0, ~t[0], 11'h0}, np_tx_word & 16'h0800);
    end
    rc("np_tx_tog", `REG_NP_TX, 16'hB7FF);
    pb = 16'hE5A3;
    pn = 16'h7C5A;
    {pb_v, pn_v} = 2'b11;
    cyc(1);
    {pb_v, pn_v} = 2'b00;
    pb = 16'h0000;
    pn = 16'h0000;
    rc("partner_base", `REG_PARTNER, 16'hE5A3);
    rc("partner_np", `REG_NP_RX, 16'h7C5A);
    rc("expand_rst", `REG_EXPAND, 16'h000D);
    rc("expand_live", `REG_EXPAND, 16'h000F);
    {pdf, page_live} = 2'b10;
    cyc(1);
    {pdf, page_live} = 2'b01;
    rc("expand_evt", `REG_EXPAND, 16'h001D);
    rc("expand_clr", `REG_EXPAND, 16'h000F);
    {nxt_able, an_able} = 2'b00;
    rc("expand_caps", `REG_EXPAND, 16'h0006);
    rc("unmapped", 5'h1F, 16'h0000);
    soft_rst_req = 1'b1;
    cyc(1);
    soft_rst_req = 1'b0;
    `CHK("busy_on", 16'h0001, {15'h0, busy});
    `CHK("advert_soft", ADV, advert_word);
    `CHK("np_soft", 16'h2001, np_tx_word);
    n = 0;
    // controller holds off until the soft reset window is over
    while (busy === 1'b1 && n < 2000) begin
      cyc(1);
      n++;
    end
    `CHK("busy_len", 16'(`SW_RST_CYC), 16'(n));
    rc("advert_after", `REG_ADVERT, ADV);
    rc("np_tx_after", `REG_NP_TX, 16'h2001);
    test_done();
  end
endmodule // testbench
